// *** nat_pkg.sv ***
// Constants for the nibble datapath with table fetch.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package nat_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_EXEC    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_DREG    = 8'h08;
  localparam logic [7:0] OFS_EREG    = 8'h0C;
  localparam logic [7:0] OFS_CFG     = 8'h10;
  localparam logic [7:0] OFS_DPTR    = 8'h14;
  localparam logic [7:0] OFS_RAMDATA = 8'h18;
  localparam logic [7:0] OFS_ROMADDR = 8'h1C;
  localparam logic [7:0] OFS_ROMDATA = 8'h20;

  // Field positions
  localparam int EXEC_OP_LSB  = 0;
  localparam int EXEC_ARG_LSB = 4;
  localparam int CFG_URS_BIT  = 2;
  localparam int ROM_CY_BIT   = 8;

  localparam int NIB_W   = 4;
  localparam int DREG_W  = 3;
  localparam int PAGE_W  = 3;
  localparam int ROM_AW  = 10;
  localparam int ROM_W   = 9;
  localparam int SP_W    = 3;

  // Reset values
  localparam logic [3:0] RST_NIB  = 4'h0;
  localparam logic [1:0] RST_LO   = 2'h0;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_LOAD  = 4'h1,
    OP_TABLE_FETCH_PAGE  = 4'h2,
    OP_AM    = 4'h3,
    OP_AMC   = 4'h4,
    OP_AISK  = 4'h5,
    OP_SC    = 4'h6,
    OP_RC    = 4'h7,
    OP_SZC   = 4'h8,
    OP_CMA   = 4'h9,
    OP_RAR   = 4'hA,
    OP_BITWISE_LOGIC_OP  = 4'hB,
    OP_TABLE_UPPER_BIT_SET_OP  = 4'hC
  } nat_op_t;

  typedef enum logic [1:0] {
    LO_XOR = 2'h0,
    LO_OR  = 2'h1,
    LO_AND = 2'h2
  } nat_lo_t;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_FETCH = 1'b1
  } nat_state_t;

endpackage

// *** nat_core.sv ***
// Nibble accumulator datapath with ROM table fetch, behind Wishbone.
// Assumes a classic single-cycle Wishbone master; one access at a time.
// Register map, byte offsets on the Wishbone bus
//   0x00 EXEC     write: [3:0] opcode, [7:4] operand; reads as zero
//   0x04 STATUS   read only, layout below
//   0x08 DREG     [2:0] D register, middle part of the table address
//   0x0C EREG     [3:0] E register, second operand of the logic op
//   0x10 CFG      [1:0] gate function, [2] table upper bit select
//   0x14 DPTR     data pointer into the nibble RAM
//   0x18 RAMDATA  [3:0] nibble at the data pointer
//   0x1C ROMADDR  [9:0] loader address into the table ROM
//   0x20 ROMDATA  [8:0] table word at the loader address
//
// Opcodes in EXEC
//   0 nop, 1 immediate_load, 2 table_fetch_page, 3 add_memory,
//   4 add_memory_carry, 5 add_immediate_skip, 6 carry_set_op,
//   7 carry_clear_op, 8 skip_if_no_carry, 9 invert_accumulator,
//   A rotate_right_through_carry, B bitwise_logic_op,
//   C table_upper_bit_set_op, D to F nop
//
// STATUS layout
//   [3:0] A, [7:4] B, [8] zero, [10:9] gate function, [11] upper select,
//   [12] carry, [13] skip pending, [14] previous was a load,
//   [17:15] stack level, upper bits zero
//
// Timing
//   Every access is acked one cycle after it is taken.
//   An executed table fetch takes one extra cycle for the ROM read;
//   the stack level shows one in that cycle and the ack follows it.
//   Ack stands one cycle; a request is not taken while ack is high.
//
// Limitations
//   Byte lanes: most registers need lane 0; ROMDATA needs lanes 0 and 1.
//   Writes that lack a needed lane are acked and dropped.
//   Gate function 3 behaves as and.
//   RAM and ROM keep their contents through reset.
module nat_core #(
  parameter int RAM_AW = 5
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  // Core state
  output logic             skip_pend_o,
  output logic [2:0]       stack_level_o
);

  localparam int RAM_WORDS = 1 << RAM_AW;

  if (RAM_AW < 1 || RAM_AW > 8) begin : g_chk
    $error("RAM_AW must lie between 1 and 8");
  end

  typedef struct packed {
    nat_pkg::nat_state_t        st;
    logic [3:0]                 acc;
    logic [3:0]                 bhi;
    logic                       cy;
    logic                       table_upper_bit_select;
    logic [1:0]                 lo;
    logic [2:0]                 dreg;
    logic [3:0]                 ereg;
    logic [RAM_AW-1:0]          dp;
    logic [9:0]                 rom_addr;
    logic [9:0]                 tab_addr;
    logic [2:0]                 sp;
    logic                       skip;
    logic                       prev_load;
    logic                       ack;
    logic [31:0]                dat;
  } nat_core_state_t;

  nat_core_state_t st_ff;
  nat_core_state_t nxt_st;

  logic [3:0] ram_ff [RAM_WORDS];
  logic [8:0] rom_ff [1 << nat_pkg::ROM_AW];

  logic             req;
  logic             wr_lane0;
  logic             wr_lane1;
  nat_pkg::nat_op_t op;
  logic [3:0]       arg;
  logic [3:0]       mem_nib;
  logic [8:0]       tab_word;
  logic             ram_we;
  logic [3:0]       ram_wdata;
  logic             rom_we;

  // Four-bit add giving carry-out in the top bit
  function automatic logic [4:0] add4(input logic [3:0] x,
                                      input logic [3:0] y,
                                      input logic       ci);
    add4 = {1'b0, x} + {1'b0, y} + {4'h0, ci};
  endfunction

  function automatic logic [3:0] gate4(input logic [1:0] sel,
                                       input logic [3:0] x,
                                       input logic [3:0] y);
    case (sel)
      nat_pkg::LO_XOR: gate4 = x ^ y;
      nat_pkg::LO_OR:  gate4 = x | y;
      default:         gate4 = x & y;
    endcase
  endfunction

  assign req      = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
  assign wr_lane1 = req & wb_we_i & wb_sel_i[1];
  assign op       = nat_pkg::nat_op_t'(wb_dat_i[nat_pkg::EXEC_OP_LSB +: 4]);
  assign arg      = wb_dat_i[nat_pkg::EXEC_ARG_LSB +: 4];
  assign mem_nib  = ram_ff[st_ff.dp];
  assign tab_word = rom_ff[st_ff.tab_addr];

  always_comb begin
    logic [4:0] sum;
    logic       exec;
    sum       = 5'h00;
    exec      = 1'b0;
    nxt_st    = st_ff;
    ram_we    = 1'b0;
    ram_wdata = wb_dat_i[3:0];
    rom_we    = 1'b0;
    nxt_st.ack = 1'b0;
    case (st_ff.st)
      nat_pkg::ST_FETCH: begin
        // low byte to B and A
        nxt_st.bhi = tab_word[7:4];
        nxt_st.acc = tab_word[3:0];
        if (st_ff.table_upper_bit_select) begin
          nxt_st.cy = tab_word[nat_pkg::ROM_CY_BIT];
        end
        nxt_st.sp  = st_ff.sp - 3'h1;
        nxt_st.st  = nat_pkg::ST_IDLE;
        nxt_st.ack = 1'b1;
        nxt_st.dat = 32'h0000_0000;
      end
      default: begin
        if (req) begin
          nxt_st.ack = 1'b1;
          nxt_st.dat = 32'h0000_0000;
          if (wb_we_i) begin
            case (wb_adr_i)
              nat_pkg::OFS_EXEC: exec = wr_lane0;
              nat_pkg::OFS_DREG: begin
                if (wr_lane0) nxt_st.dreg = wb_dat_i[2:0];
              end
              nat_pkg::OFS_EREG: begin
                if (wr_lane0) nxt_st.ereg = wb_dat_i[3:0];
              end
              nat_pkg::OFS_CFG: begin
                if (wr_lane0) begin
                  nxt_st.lo  = wb_dat_i[1:0];
                  nxt_st.table_upper_bit_select = wb_dat_i[nat_pkg::CFG_URS_BIT];
                end
              end
              nat_pkg::OFS_DPTR: begin
                if (wr_lane0) nxt_st.dp = wb_dat_i[RAM_AW-1:0];
              end
              nat_pkg::OFS_RAMDATA: ram_we = wr_lane0;
              nat_pkg::OFS_ROMADDR: begin
                if (wr_lane0) nxt_st.rom_addr[7:0] = wb_dat_i[7:0];
                if (wr_lane1) nxt_st.rom_addr[9:8] = wb_dat_i[9:8];
              end
              nat_pkg::OFS_ROMDATA: rom_we = wr_lane0 & wr_lane1;
              default: ;
            endcase
          end else begin
            case (wb_adr_i)
              // Eighteen status bits, zero above
              nat_pkg::OFS_STATUS: nxt_st.dat = {
                  14'h0000,
                  st_ff.sp,
                  st_ff.prev_load,
                  st_ff.skip,
                  st_ff.cy,
                  st_ff.table_upper_bit_select,
                  st_ff.lo,
                  1'b0,
                  st_ff.bhi,
                  st_ff.acc};
              nat_pkg::OFS_DREG:    nxt_st.dat = {29'h0, st_ff.dreg};
              nat_pkg::OFS_EREG:    nxt_st.dat = {28'h0, st_ff.ereg};
              nat_pkg::OFS_CFG:     nxt_st.dat = {29'h0, st_ff.table_upper_bit_select, st_ff.lo};
              nat_pkg::OFS_DPTR:
                nxt_st.dat = {{(32-RAM_AW){1'b0}}, st_ff.dp};
              nat_pkg::OFS_RAMDATA: nxt_st.dat = {28'h0, mem_nib};
              nat_pkg::OFS_ROMADDR: nxt_st.dat = {22'h0, st_ff.rom_addr};
              nat_pkg::OFS_ROMDATA:
                nxt_st.dat = {23'h0, rom_ff[st_ff.rom_addr]};
              default: nxt_st.dat = 32'h0000_0000;
            endcase
          end
        end
        // Skip flag is cleared only here and by reset, so no set/clear race
        if (exec) begin
          nxt_st.prev_load = (op == nat_pkg::OP_LOAD);
          nxt_st.skip      = 1'b0;
          if (st_ff.skip) begin
          end else if (op == nat_pkg::OP_LOAD && st_ff.prev_load) begin
          end else begin
            case (op)
              nat_pkg::OP_LOAD: nxt_st.acc = arg;
              nat_pkg::OP_TABLE_FETCH_PAGE: begin
                nxt_st.tab_addr = {arg[nat_pkg::PAGE_W-1:0], st_ff.dreg,
                                   st_ff.acc};
                nxt_st.sp  = st_ff.sp + 3'h1;
                nxt_st.st  = nat_pkg::ST_FETCH;
                nxt_st.ack = 1'b0;
              end
              nat_pkg::OP_AM: begin
                sum        = add4(st_ff.acc, mem_nib, 1'b0);
                nxt_st.acc = sum[3:0];
              end
              nat_pkg::OP_AMC: begin
                sum        = add4(st_ff.acc, mem_nib, st_ff.cy);
                nxt_st.acc = sum[3:0];
                nxt_st.cy  = sum[4];
              end
              nat_pkg::OP_AISK: begin
                sum        = add4(st_ff.acc, arg, 1'b0);
                nxt_st.acc = sum[3:0];
                nxt_st.skip = ~sum[4];
              end
              nat_pkg::OP_SC:   nxt_st.cy = 1'b1;
              nat_pkg::OP_RC:   nxt_st.cy = 1'b0;
              nat_pkg::OP_SZC:  nxt_st.skip = ~st_ff.cy;
              nat_pkg::OP_CMA:  nxt_st.acc = ~st_ff.acc;
              nat_pkg::OP_RAR: begin
                nxt_st.acc = {st_ff.cy, st_ff.acc[3:1]};
                nxt_st.cy  = st_ff.acc[0];
              end
              nat_pkg::OP_BITWISE_LOGIC_OP:
                nxt_st.acc = gate4(st_ff.lo, st_ff.acc, st_ff.ereg);
              nat_pkg::OP_TABLE_UPPER_BIT_SET_OP: nxt_st.table_upper_bit_select = 1'b1;
              default: ;
            endcase
          end
        end
      end
    endcase
    if (rst) begin
      nxt_st          = '0;
      nxt_st.st       = nat_pkg::ST_IDLE;
      nxt_st.acc      = nat_pkg::RST_NIB;
      nxt_st.bhi      = nat_pkg::RST_NIB;
      nxt_st.ereg     = nat_pkg::RST_NIB;
      nxt_st.lo       = nat_pkg::RST_LO;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  // Memories are not cleared by reset; software loads them
  // Kept out of the state struct: too large to clear each reset
  always_ff @(posedge clk) begin
    if (ram_we && !rst) begin
      ram_ff[st_ff.dp] <= ram_wdata;
    end
    if (rom_we && !rst) begin
      rom_ff[st_ff.rom_addr] <= wb_dat_i[8:0];
    end
  end

  assign wb_ack_o      = st_ff.ack;
  assign wb_dat_o      = st_ff.dat;
  assign skip_pend_o   = st_ff.skip;
  assign stack_level_o = st_ff.sp;

endmodule

// *** nat_assertions.sv ***
// Checker for the bus handshake, stack and skip flag of nat_core.
// Sees only nat_core ports; bound from the testbench top file.
module nat_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        skip_pend_o,
  input wire logic [2:0]  stack_level_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic exw;
  logic table_fetch_page;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign exw  = take && wb_we_i && wb_adr_i == nat_pkg::OFS_EXEC;
  // Only a fresh fetch, not its second cycle
  assign table_fetch_page = exw && wb_dat_i[3:0] == 4'h2 && stack_level_o == 3'h0;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_bound_a: assert property (take |-> ##[1:2] wb_ack_o)
    else $error("request not answered");
  stack_hold_a: assert property (stack_level_o != 3'h0 |->
    stack_level_o == 3'h1 ##1 (wb_ack_o && stack_level_o == 3'h0))
    else $error("stack not restored");
  table_fetch_page_stack_a: assert property (table_fetch_page && !skip_pend_o |=>
    stack_level_o == 3'h1 && !wb_ack_o)
    else $error("fetch did not use a stack stage");
  skip_table_fetch_page_a: assert property (table_fetch_page && skip_pend_o |=>
    stack_level_o == 3'h0 && wb_ack_o)
    else $error("skipped fetch touched the stack");
  stack_cause_a: assert property (stack_level_o != 3'h0 |-> exw)
    else $error("stack used without a fetch");
  skip_cause_a: assert property (!$stable(skip_pend_o) |->
    wb_ack_o && wb_we_i && wb_adr_i == nat_pkg::OFS_EXEC)
    else $error("skip flag moved without an instruction");
  write_dat_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("write returned data");
endmodule

// *** nat_core_tb.sv ***
// Self-checking bench for nat_core over classic Wishbone.
// Assumes the register map and opcodes of nat_pkg.
module nat_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        ack;
  logic [31:0] rdat;
  logic        skip;
  logic [2:0]  lvl;
  logic [31:0] q;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  nat_core i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .skip_pend_o(skip),
    .stack_level_o(lvl));
  initial forever #25 clk = ~clk;
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, generous for about 70 accesses
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic ex(input nat_pkg::nat_op_t op, input logic [3:0] n);
    wb(1'b1, nat_pkg::OFS_EXEC, {24'h0, n, op});
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Reads status and compares carry, B and A
  task automatic st(input logic [3:0] a, input logic [3:0] b, input logic c);
    wb(1'b0, nat_pkg::OFS_STATUS, 32'h0);
    chk({19'h0, q[12], 4'h0, q[7:0]}, {19'h0, c, 4'h0, b, a});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, nat_pkg::OFS_STATUS, 32'h0); chk(q, 32'h0);
    ex(nat_pkg::OP_LOAD, 4'h5); st(4'h5, 4'h0, 1'b0);
    ex(nat_pkg::OP_LOAD, 4'h9); ex(nat_pkg::OP_LOAD, 4'h7);
    st(4'h5, 4'h0, 1'b0);
    ex(nat_pkg::OP_NOP, 4'h0); ex(nat_pkg::OP_LOAD, 4'h3);
    ex(nat_pkg::OP_SC, 4'h0); st(4'h3, 4'h0, 1'b1);
    wb(1'b1, nat_pkg::OFS_DPTR, 32'h2); wb(1'b1, nat_pkg::OFS_RAMDATA, 32'hE);
    ex(nat_pkg::OP_AM, 4'h0); st(4'h1, 4'h0, 1'b1);
    ex(nat_pkg::OP_AMC, 4'h0); st(4'h0, 4'h0, 1'b1);
    ex(nat_pkg::OP_RC, 4'h0); st(4'h0, 4'h0, 1'b0);
    ex(nat_pkg::OP_AMC, 4'h0); st(4'hE, 4'h0, 1'b0);
    ex(nat_pkg::OP_AISK, 4'h3); ex(nat_pkg::OP_CMA, 4'h0);
    st(4'hE, 4'h0, 1'b0);
    ex(nat_pkg::OP_AISK, 4'h1); chk(skip, 1'b1);
    ex(nat_pkg::OP_CMA, 4'h0); st(4'hF, 4'h0, 1'b0);
    ex(nat_pkg::OP_SZC, 4'h0); ex(nat_pkg::OP_SC, 4'h0);
    st(4'hF, 4'h0, 1'b0);
    ex(nat_pkg::OP_SC, 4'h0); ex(nat_pkg::OP_SZC, 4'h0);
    ex(nat_pkg::OP_CMA, 4'h0); st(4'h0, 4'h0, 1'b1);
    ex(nat_pkg::OP_LOAD, 4'h5); ex(nat_pkg::OP_RAR, 4'h0);
    st(4'hA, 4'h0, 1'b1);
    wb(1'b1, nat_pkg::OFS_EREG, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, nat_pkg::OFS_CFG, i);
      ex(nat_pkg::OP_LOAD, 4'h5); ex(nat_pkg::OP_BITWISE_LOGIC_OP, 4'h0);
      st(i == 0 ? 4'h3 : i == 1 ? 4'h7 : 4'h4, 4'h0, 1'b1);
    end
    // Page 3, D 5, A C gives word 1DC
    wb(1'b1, nat_pkg::OFS_ROMADDR, 32'h1DC);
    wb(1'b1, nat_pkg::OFS_ROMDATA, 32'h1A7);
    wb(1'b1, nat_pkg::OFS_DREG, 32'h5); wb(1'b1, nat_pkg::OFS_CFG, 32'h0);
    ex(nat_pkg::OP_RC, 4'h0); ex(nat_pkg::OP_LOAD, 4'hC);
    ex(nat_pkg::OP_TABLE_FETCH_PAGE, 4'h3); st(4'h7, 4'hA, 1'b0);
    ex(nat_pkg::OP_TABLE_UPPER_BIT_SET_OP, 4'h0); ex(nat_pkg::OP_LOAD, 4'hC);
    ex(nat_pkg::OP_TABLE_FETCH_PAGE, 4'h3); st(4'h7, 4'hA, 1'b1);
    chk({29'h0, q[17:15]}, 32'h0);
    ex(nat_pkg::OP_AISK, 4'h0); ex(nat_pkg::OP_TABLE_FETCH_PAGE, 4'h1);
    st(4'h7, 4'hA, 1'b1);
    wb(1'b0, nat_pkg::OFS_DREG, 32'h0); chk(q, 32'h5);
    wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
    wb(1'b0, nat_pkg::OFS_EXEC, 32'h0); chk(q, 32'h0);
    final_report();
  end
endmodule
bind nat_core nat_assertions i_chk (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .skip_pend_o(skip_pend_o),
  .stack_level_o(stack_level_o));
